// File: rtl/secp_pkg.sv
// Package for the serial EEPROM command and protection block
package secp_pkg;

    // ==================================================
    // Opcodes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_ARR_RD = 8'h03;
    localparam logic [7:0] OP_ARR_WR = 8'h02;

    // ==================================================
    // Status byte field positions
    localparam int ST_BUSY = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_GUARD_LO = 2;
    localparam int ST_GUARD_HI = 3;
    localparam int ST_LOCK = 7;

    // ==================================================
    // Reset values of the non-volatile bits
    localparam logic [1:0] GUARD_RESET = 2'h0;
    localparam logic LOCK_RESET = 1'b0;

    // ==================================================
    // Guard boundaries
    localparam logic [15:0] GUARD_QUARTER_BASE = 16'hc000;
    localparam logic [15:0] GUARD_HALF_BASE = 16'h8000;

    // ==================================================
    // Timing
    localparam int CORE_CLK_HZ = 20_000_000;
    localparam int WRITE_TIME_US = 5000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * (CORE_CLK_HZ / 1_000_000);

    // ==================================================
    // Link side decoder state
    typedef enum logic [2:0] {
        SECP_ST_OPCODE = 3'b000,
        SECP_ST_ADDR = 3'b001,
        SECP_ST_DATA = 3'b010,
        SECP_ST_READ = 3'b011,
        SECP_ST_WAIT = 3'b100,
        SECP_ST_IGNORE = 3'b101
    } secp_dec_t;

    // Command handed to the core domain at the end of a frame
    typedef struct packed {
        logic [7:0] opcode;
        logic [15:0] addr;
        logic [7:0] data;
        logic aligned;
        logic has_data;
    } secp_cmd_t;

    typedef struct packed {
        secp_dec_t st;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] opcode;
        logic [15:0] addr;
        logic addr_hi;
        logic [7:0] data;
        logic has_data;
    } secp_link_t;

    typedef struct packed {
        logic [7:0] out_byte;
        logic [2:0] out_cnt;
        logic drive;
        logic so;
    } secp_out_t;

    typedef struct packed {
        logic [2:0] sel_sync;
        logic [2:0] tog_sync;
        logic sel_seen_high;
        logic latch;
        logic busy;
        logic [1:0] guard;
        logic lock;
        logic [1:0] pend_guard;
        logic pend_lock;
        logic pend_sr;
        logic [31:0] timer;
        logic [2:0] wp_sync;
        logic array_wr_pulse;
        logic [15:0] array_wr_addr;
        logic [7:0] array_wr_data;
    } secp_core_t;

endpackage

// File: rtl/secp_sync.sv
// Three-flop synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module secp_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reset_val,
    // Signal
    input wire logic din,
    output logic dout
);
    logic [2:0] sync_q;
    logic out_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_q <= 3'h0;
            out_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], din};
            // Only change once stages two and three agree
            if (sync_q[1] == sync_q[2]) begin
                out_q <= sync_q[2];
            end
        end
    end

    assign dout = (!rst_b) ? reset_val : out_q;
endmodule
`default_nettype wire

// File: rtl/secp_top.sv
// Serial EEPROM instruction decoder, status register and protection
`timescale 1ns/1ps
`default_nettype none

module secp_top #(
    parameter int WRITE_CYCLES = secp_pkg::WRITE_CYCLES
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Serial link
    input wire logic serial_clock,
    input wire logic select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_en,
    // Protection pin
    input wire logic protect_pin_n,
    // Status view and array write request
    output logic [7:0] status_and_protect,
    output logic hardware_lock_mode,
    output logic array_wr_valid,
    output logic [15:0] array_wr_addr,
    output logic [7:0] array_wr_data,
    output logic array_rd_refused
);

    // ==================================================
    // Link domain: input shifter on rising serial_clock
    secp_pkg::secp_link_t lk_q, lk_d;
    secp_pkg::secp_cmd_t cmd_q;
    logic cmd_tog_q;
    logic [7:0] stat_link_q;
    logic busy_link;

    always_comb begin
        logic [7:0] nxt;
        nxt = {lk_q.shift[6:0], serial_in};
        lk_d = lk_q;
        lk_d.shift = nxt;
        lk_d.bit_cnt = lk_q.bit_cnt + 3'h1;
        case (lk_q.st)
            secp_pkg::SECP_ST_OPCODE: begin
                if (lk_q.bit_cnt == 3'h7) begin
                    lk_d.opcode = nxt;
                    case (nxt)
                        secp_pkg::OP_SET_LATCH, secp_pkg::OP_CLR_LATCH: begin
                            lk_d.st = secp_pkg::SECP_ST_WAIT;
                        end
                        secp_pkg::OP_STAT_RD: begin
                            lk_d.st = secp_pkg::SECP_ST_READ;
                        end
                        secp_pkg::OP_STAT_WR: begin
                            lk_d.st = secp_pkg::SECP_ST_DATA;
                        end
                        secp_pkg::OP_ARR_WR: begin
                            lk_d.st = secp_pkg::SECP_ST_ADDR;
                        end
                        secp_pkg::OP_ARR_RD: begin
                            lk_d.st = busy_link ? secp_pkg::SECP_ST_IGNORE
                                                : secp_pkg::SECP_ST_ADDR;
                        end
                        default: begin
                            lk_d.st = secp_pkg::SECP_ST_IGNORE;
                        end
                    endcase
                end
            end
            secp_pkg::SECP_ST_ADDR: begin
                if (lk_q.bit_cnt == 3'h7) begin
                    lk_d.addr_hi = !lk_q.addr_hi;
                    if (!lk_q.addr_hi) begin
                        lk_d.addr[15:8] = nxt;
                    end else begin
                        lk_d.addr[7:0] = nxt;
                        lk_d.st = (lk_q.opcode == secp_pkg::OP_ARR_RD)
                                  ? secp_pkg::SECP_ST_READ : secp_pkg::SECP_ST_DATA;
                    end
                end
            end
            secp_pkg::SECP_ST_DATA: begin
                if (lk_q.bit_cnt == 3'h7) begin
                    // Only the last byte is kept; array data path lives elsewhere
                    lk_d.data = nxt;
                    lk_d.has_data = 1'b1;
                end
            end
            secp_pkg::SECP_ST_WAIT: begin
                lk_d.st = secp_pkg::SECP_ST_IGNORE;
            end
            secp_pkg::SECP_ST_READ, secp_pkg::SECP_ST_IGNORE: begin
            end
            default: begin
                lk_d.st = secp_pkg::SECP_ST_IGNORE;
            end
        endcase
    end

    // Frame state reset by select high; link clock may stop between frames
    always_ff @(posedge serial_clock or posedge select_n) begin
        if (select_n) begin
            lk_q <= '0;
        end else begin
            lk_q <= lk_d;
        end
    end

    // ==================================================
    // Frame end: capture command on select rise, toggle to core
    always_ff @(posedge select_n or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q <= '0;
            cmd_tog_q <= 1'b0;
        end else begin
            cmd_q.opcode <= (lk_q.st == secp_pkg::SECP_ST_IGNORE) ? 8'h00 : lk_q.opcode;
            cmd_q.addr <= lk_q.addr;
            cmd_q.data <= lk_q.data;
            // Bit counter wrapped to zero means byte boundary
            cmd_q.aligned <= (lk_q.bit_cnt == 3'h0);
            cmd_q.has_data <= lk_q.has_data;
            cmd_tog_q <= !cmd_tog_q;
        end
    end

    // ==================================================
    // Link domain: output on falling serial_clock
    secp_pkg::secp_out_t ou_q, ou_d;
    logic [2:0] busy_ls_q;

    assign busy_link = busy_ls_q[2];

    always_comb begin
        ou_d = ou_q;
        if (lk_q.st == secp_pkg::SECP_ST_READ) begin
            ou_d.drive = 1'b1;
            if (ou_q.out_cnt == 3'h0) begin
                ou_d.out_byte = {stat_link_q[6:0], 1'b0};
                ou_d.so = stat_link_q[7];
            end else begin
                ou_d.out_byte = {ou_q.out_byte[6:0], 1'b0};
                ou_d.so = ou_q.out_byte[7];
            end
            ou_d.out_cnt = ou_q.out_cnt + 3'h1;
        end
    end

    always_ff @(negedge serial_clock or posedge select_n) begin
        if (select_n) begin
            ou_q <= '0;
        end else begin
            ou_q <= ou_d;
        end
    end

    assign serial_out = ou_q.so;
    assign serial_out_en = ou_q.drive && !select_n;

    // Status crosses as a multi-bit level; sampled on every falling edge, loaded into the shifter once per byte
    always_ff @(negedge serial_clock) begin
        busy_ls_q <= {busy_ls_q[1:0], status_and_protect[secp_pkg::ST_BUSY]};
        stat_link_q <= status_and_protect;
    end

    // ==================================================
    // Core domain
    secp_pkg::secp_core_t co_q, co_d;
    logic sel_high;
    logic frame_ev;
    logic wp_low;
    logic lock_mode;
    logic guarded;

    secp_sync u_sel_sync (
        .clk(core_clk),
        .rst_b(rst_b),
        .reset_val(1'b0),
        .din(select_n),
        .dout(sel_high)
    );

    secp_sync u_wp_sync (
        .clk(core_clk),
        .rst_b(rst_b),
        .reset_val(1'b1),
        .din(!protect_pin_n),
        .dout(wp_low)
    );

    assign frame_ev = co_q.tog_sync[2] != co_q.tog_sync[1];
    assign lock_mode = co_q.lock && wp_low;

    always_comb begin
        guarded = 1'b0;
        case (co_q.guard)
            2'h1: guarded = cmd_q.addr >= secp_pkg::GUARD_QUARTER_BASE;
            2'h2: guarded = cmd_q.addr >= secp_pkg::GUARD_HALF_BASE;
            2'h3: guarded = 1'b1;
            default: guarded = 1'b0;
        endcase
    end

    always_comb begin
        co_d = co_q;
        co_d.tog_sync = {co_q.tog_sync[1:0], cmd_tog_q};
        co_d.sel_seen_high = co_q.sel_seen_high | sel_high;
        co_d.array_wr_pulse = 1'b0;
        if (co_q.busy) begin
            if (co_q.timer == 32'h1) begin
                co_d.busy = 1'b0;
                co_d.latch = 1'b0;
                co_d.timer = 32'h0;
                if (co_q.pend_sr) begin
                    co_d.guard = co_q.pend_guard;
                    co_d.lock = co_q.pend_lock;
                    co_d.pend_sr = 1'b0;
                end
            end else begin
                co_d.timer = co_q.timer - 32'h1;
            end
        end
        // Frames before a first seen select high are ignored
        if (frame_ev && co_q.sel_seen_high && !co_q.busy) begin
            case (cmd_q.opcode)
                secp_pkg::OP_SET_LATCH: begin
                    co_d.latch = 1'b1;
                end
                secp_pkg::OP_CLR_LATCH: begin
                    co_d.latch = 1'b0;
                end
                secp_pkg::OP_STAT_WR: begin
                    if (co_q.latch && cmd_q.aligned && cmd_q.has_data
                        && !lock_mode) begin
                        co_d.pend_guard = {cmd_q.data[secp_pkg::ST_GUARD_HI],
                                           cmd_q.data[secp_pkg::ST_GUARD_LO]};
                        co_d.pend_lock = cmd_q.data[secp_pkg::ST_LOCK];
                        co_d.pend_sr = 1'b1;
                        co_d.busy = 1'b1;
                        co_d.timer = 32'(WRITE_CYCLES);
                    end
                end
                secp_pkg::OP_ARR_WR: begin
                    if (co_q.latch && cmd_q.aligned && cmd_q.has_data
                        && !guarded) begin
                        co_d.array_wr_pulse = 1'b1;
                        co_d.array_wr_addr = cmd_q.addr;
                        co_d.array_wr_data = cmd_q.data;
                        co_d.busy = 1'b1;
                        co_d.timer = 32'(WRITE_CYCLES);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            co_q <= '0;
            co_q.guard <= secp_pkg::GUARD_RESET;
            co_q.lock <= secp_pkg::LOCK_RESET;
        end else begin
            co_q <= co_d;
        end
    end

    always_comb begin
        status_and_protect = 8'h00;
        status_and_protect[secp_pkg::ST_BUSY] = co_q.busy;
        status_and_protect[secp_pkg::ST_LATCH] = co_q.latch;
        status_and_protect[secp_pkg::ST_GUARD_LO] = co_q.guard[0];
        status_and_protect[secp_pkg::ST_GUARD_HI] = co_q.guard[1];
        status_and_protect[secp_pkg::ST_LOCK] = co_q.lock;
    end

    assign hardware_lock_mode = lock_mode;
    assign array_wr_valid = co_q.array_wr_pulse;
    assign array_wr_addr = co_q.array_wr_addr;
    assign array_wr_data = co_q.array_wr_data;
    assign array_rd_refused = co_q.busy;

endmodule
`default_nettype wire

// File: test/secp_top_properties.sv
// Checker for the serial EEPROM command and protection block
`timescale 1ns/1ps
`default_nettype none
module secp_top_checker #(
    parameter int WRITE_CYCLES = secp_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Link and pin
    input wire logic select_n,
    input wire logic serial_out_en,
    input wire logic protect_pin_n,
    // Status and array side
    input wire logic [7:0] status_and_protect,
    input wire logic hardware_lock_mode,
    input wire logic array_wr_valid,
    input wire logic [15:0] array_wr_addr,
    input wire logic array_rd_refused
);
    // ==================================================
    // Busy length counter
    logic [31:0] busy_cnt_q;
    always_ff @(posedge core_clk) begin
        if (!rst_b || !status_and_protect[0]) busy_cnt_q <= 32'h0;
        else busy_cnt_q <= busy_cnt_q + 32'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // ==================================================
    // Properties
    out_en_sel_a: assert property (serial_out_en
        |-> !select_n && !$past(select_n, 8))
        else $error("serial output driven while deselected or too early");
    lock_src_a: assert property (hardware_lock_mode
        |-> status_and_protect[7] && !$past(protect_pin_n, 4))
        else $error("lock mode without lock bit or protect pin low");
    lock_on_a: assert property ((status_and_protect[7] && !protect_pin_n) [*8]
        |-> hardware_lock_mode) else $error("lock mode not entered");
    rd_refuse_a: assert property (array_rd_refused == status_and_protect[0])
        else $error("read refusal differs from busy");
    busy_len_a: assert property ($fell(status_and_protect[0])
        |-> busy_cnt_q == WRITE_CYCLES) else $error("busy period wrong length");
    latch_end_a: assert property ($fell(status_and_protect[0])
        |-> ##[0:1] !status_and_protect[1]) else $error("latch kept after write");
    guard_hold_a: assert property (status_and_protect[0] && $past(status_and_protect[0])
        |-> $stable(status_and_protect[7:2])) else $error("guard changed while busy");
    wr_guard_a: assert property (array_wr_valid |-> status_and_protect[3:2] == 2'h0
        || (status_and_protect[3:2] == 2'h1 && array_wr_addr < secp_pkg::GUARD_QUARTER_BASE)
        || (status_and_protect[3:2] == 2'h2 && array_wr_addr < secp_pkg::GUARD_HALF_BASE))
        else $error("write to guarded address");
    wr_latch_a: assert property (array_wr_valid |-> status_and_protect[1])
        else $error("write accepted without latch");
    latch_sel_a: assert property ($rose(status_and_protect[1]) |-> select_n)
        else $error("latch set while selected");
endmodule

bind secp_top secp_top_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .select_n(select_n),
    .serial_out_en(serial_out_en),
    .protect_pin_n(protect_pin_n),
    .status_and_protect(status_and_protect),
    .hardware_lock_mode(hardware_lock_mode),
    .array_wr_valid(array_wr_valid),
    .array_wr_addr(array_wr_addr),
    .array_rd_refused(array_rd_refused)
);
`default_nettype wire

// File: test/secp_master.sv
// Serial bus master model, clock mode 0
`timescale 1ns/1ps
`default_nettype none
module secp_master (
    // Link pins
    output logic serial_clock,
    output logic select_n,
    output logic serial_in,
    input wire logic serial_out,
    // Last byte seen on the data out line
    output logic [7:0] rx_byte,
    output logic rx_done
);
    initial begin
        serial_clock = 1'b0;
        select_n = 1'b0;
        serial_in = 1'b0;
        rx_byte = 8'h00;
        rx_done = 1'b0;
        // A real deselect edge after start, so link-side flops leave unknown
        #1 select_n = 1'b1;
    end

    // Clock stands low outside frames; 160 ns link period
    task automatic xfer(input logic [31:0] bits, input int n);
        #13 select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_in = bits[31 - i];
            #80 rx_byte = {rx_byte[6:0], serial_out};
            serial_clock = 1'b1;
            #80 serial_clock = 1'b0;
        end
        #40 select_n = 1'b1;
        // No pull on the data line, so show the inverse once released
        serial_in = ~serial_in;
        rx_done = 1'b1;
        #10 rx_done = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Testbench for the serial EEPROM command and protection block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int WCYC = 200;
    logic core_clk;
    logic rst_b;
    logic protect_pin_n;
    logic serial_clock;
    logic select_n;
    logic serial_in;
    logic serial_out;
    logic [7:0] status_and_protect;
    logic hardware_lock_mode;
    logic array_wr_valid;
    logic [15:0] array_wr_addr;
    logic [7:0] array_wr_data;
    logic [7:0] rx_byte;
    logic rx_done;
    logic rd_frame;
    logic [24:0] q[$];
    int n_errors;
    int n_compared;

    secp_top #(.WRITE_CYCLES(WCYC)) i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .serial_clock(serial_clock),
        .select_n(select_n), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_en(), .protect_pin_n(protect_pin_n),
        .status_and_protect(status_and_protect), .hardware_lock_mode(hardware_lock_mode),
        .array_wr_valid(array_wr_valid), .array_wr_addr(array_wr_addr),
        .array_wr_data(array_wr_data), .array_rd_refused()
    );
    secp_master i_mst (
        .serial_clock(serial_clock), .select_n(select_n), .serial_in(serial_in),
        .serial_out(serial_out), .rx_byte(rx_byte), .rx_done(rx_done)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ==================================================
    // Result checking
    task automatic check(input logic [24:0] act);
        logic [24:0] exp;
        exp = (q.size() > 0) ? q.pop_front() : 25'h1ffffff;
        n_compared++;
        if (exp !== act) begin
            $display("CHECK FAILED at %0t exp %h act %h", $time, exp, act);
            n_errors++;
        end
    endtask
    always @(posedge core_clk)
        if (array_wr_valid === 1'b1) check({1'b0, array_wr_addr, array_wr_data});
    always @(posedge rx_done)
        if (rd_frame) check({1'b1, 16'h0000, rx_byte});

    task automatic conclude();
        if (q.size() != 0) n_errors++;
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ==================================================
    // Transfers; select stays high ten cycles so the toggle crosses
    task automatic frame(input logic [31:0] bits, input int n);
        @(posedge core_clk);
        i_mst.xfer(bits, n);
        repeat (10) @(posedge core_clk);
    endtask
    task automatic rdst(input logic [7:0] st);
        q.push_back({1'b1, 16'h0000, st});
        rd_frame = 1'b1;
        frame({secp_pkg::OP_STAT_RD, 24'h000000}, 24);
        rd_frame = 1'b0;
    endtask
    task automatic idle();
        int k;
        k = 0;
        while (status_and_protect[0] !== 1'b0 && k < 4 * WCYC) begin
            @(posedge core_clk);
            k++;
        end
    endtask
    task automatic latch(input logic [7:0] op);
        frame({op, 24'h000000}, 8);
    endtask
    task automatic status_write_cmd(input logic [7:0] v);
        latch(secp_pkg::OP_SET_LATCH);
        frame({secp_pkg::OP_STAT_WR, v, 16'h0000}, 16);
        idle();
    endtask
    task automatic wr(input logic [15:0] a, input logic ok);
        logic [7:0] d;
        d = 8'($urandom);
        latch(secp_pkg::OP_SET_LATCH);
        if (ok) q.push_back({1'b0, a, d});
        frame({secp_pkg::OP_ARR_WR, a, d}, 32);
        idle();
        latch(secp_pkg::OP_CLR_LATCH);
    endtask

    // ==================================================
    // Main sequence
    initial begin
        logic [15:0] a;
        logic [15:0] b;
        void'($urandom(32'h172a));
        rst_b = 1'b0;
        protect_pin_n = 1'b1;
        rd_frame = 1'b0;
        n_errors = 0;
        n_compared = 0;
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge core_clk);
        rdst(8'h00);
        latch(8'h07);
        rdst(8'h00);
        frame({secp_pkg::OP_ARR_WR, 16'h1234, 8'h5a}, 32);
        frame({secp_pkg::OP_STAT_WR, 8'h8c, 16'h0000}, 16);
        rdst(8'h00);
        latch(secp_pkg::OP_SET_LATCH);
        frame({secp_pkg::OP_ARR_WR, 16'h0100, 8'h33}, 31);
        frame({secp_pkg::OP_STAT_WR, 8'h8c, 16'h0000}, 17);
        frame({secp_pkg::OP_CLR_LATCH, 24'h000000}, 5);
        rdst(8'h02);
        latch(secp_pkg::OP_CLR_LATCH);
        rdst(8'h00);
        a = 16'($urandom);
        latch(secp_pkg::OP_SET_LATCH);
        rdst(8'h02);
        q.push_back({1'b0, a, 8'ha6});
        frame({secp_pkg::OP_ARR_WR, a, 8'ha6}, 32);
        rdst(8'h03);
        // Array read while busy: device stays silent, line reads back zero
        q.push_back({1'b1, 16'h0000, 8'h00});
        rd_frame = 1'b1;
        frame({secp_pkg::OP_ARR_RD, a, 8'h00}, 32);
        rd_frame = 1'b0;
        idle();
        rdst(8'h00);
        for (int g = 1; g < 4; g++) begin
            b = (g == 1) ? secp_pkg::GUARD_QUARTER_BASE
                : (g == 2) ? secp_pkg::GUARD_HALF_BASE : 16'h0000;
            status_write_cmd(8'(g << 2));
            rdst(8'(g << 2));
            wr(b | (16'($urandom) & ~b), 1'b0);
            if (g < 3) wr(b - 16'h0001, 1'b1);
        end
        status_write_cmd(8'h80);
        protect_pin_n <= 1'b0;
        status_write_cmd(8'h0c);
        rdst(8'h82);
        protect_pin_n <= 1'b1;
        status_write_cmd(8'h00);
        rdst(8'h00);
        conclude();
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
